// >>> rtl/clk_unit_ctrl.sv
// clock source, mode and divider control with a classic Wishbone slave
//
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`default_nettype none
//
// Function
// (R01) seven modes: two engaged, four bypassed, and stop
// (R02) any reset enters engaged internal mode with no software action; here only I_RST does, I_POR alone reloads just the trim
// (R03) engaged internal: output from loop on internal ref, debug from loop
// (R04) engaged external: output from loop on external ref, debug from loop
// (R05) bypassed internal: loop runs, output from internal ref, debug from loop
// (R06) bypassed internal low power: loop off, internal ref output, no debug
// (R07) bypassed external: loop runs, output from external ref, debug clock
// (R08) bypassed external low power: loop off, external ref, no debug clock
// (R09) stop: loop off, no outputs, refs follow their stop-keep bits
// (R10) bus clock is half the selected clock output
// (R11) bus divider select resets to divide-by-two
// (R12) power-on reset loads coarse trim 0x80 and fine trim 0
// (R13) other resets keep the trim values
// (R14) selected source divided by 1, 2, 4 or 8 via 2-bit select
// (R15) every source passes through the bus divider
// (R16) loop reference divider with 3-bit select
// (R17) debug clock is loop oscillator divided by fixed 2
// (R18) internal reference trimmed by 8 coarse bits plus one fine bit
// (R19) software enables regulator in stop before keeping internal ref
// (R20) drives gain, range, osc request, clock on, stop keep to oscillator
// (R21) reference divider code is a power of two, 000 divides by 1
// (R22) reference choose bit: 1 internal, 0 external
// (R23) low-power bypass turns loop off in bypass unless debug active
// (R24) mode decoded from selects; source switch is glitch-free
module clk_unit_ctrl (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic I_POR,
  input wire logic I_STOP,
  input wire logic I_DEBUG_ACTIVE,
  input wire logic I_LOOP_TICK,
  input wire logic I_IREF_TICK,
  input wire logic I_EREF_TICK,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [3:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  output logic O_OUT_TICK,
  output logic O_BUS_TICK,
  output logic O_DEBUG_TICK,
  output logic O_LOOP_REF_TICK,
  output logic O_LOOP_ENABLE,
  output logic O_IREF_ENABLE,
  output logic O_IREF_CLK_TICK,
  output logic [7:0] O_TRIM,
  output logic O_FINE_TRIM,
  output clk_unit_pkg::osc_ctrl_t O_OSC_CTRL,
  output clk_unit_pkg::mode_t O_MODE
);
  logic [7:0] ctrl1_q;
  logic [7:0] ctrl2_q;
  logic [7:0] trim_q;
  logic fine_trim_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic [1:0] act_src_q;
  logic [1:0] req_src;
  logic [2:0] reference_divider_select_sel;
  logic [1:0] bus_divider_select_sel;
  logic iref_sel;
  logic lp_by;
  logic wr_go;
  logic src_tick;
  logic ref_tick;
  logic loop_run;
  logic out_tick;
  clk_unit_pkg::mode_t mode_q;
  clk_unit_pkg::mode_t mode_d;

  assign req_src = ctrl1_q[clk_unit_pkg::SRC_LSB +: 2];
  assign reference_divider_select_sel = ctrl1_q[clk_unit_pkg::REFDIV_LSB +: 3];
  assign iref_sel = ctrl1_q[clk_unit_pkg::IREF_BIT];
  assign bus_divider_select_sel = ctrl2_q[clk_unit_pkg::BUSDIV_LSB +: 2];
  assign lp_by = ctrl2_q[clk_unit_pkg::LPBY_BIT];
  assign wr_go = I_WB_CYC && I_WB_STB && I_WB_WE && !ack_q && I_WB_SEL[0];

  // registers; I_RST lands in engaged internal mode, I_POR alone does not touch them
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      ctrl1_q <= {clk_unit_pkg::SRC_RST, clk_unit_pkg::REFDIV_RST,
                  3'h4}; // R02 R21
      ctrl2_q <= {clk_unit_pkg::BUSDIV_RST, 6'h00}; // R11
    end else if (wr_go) begin
      if (I_WB_ADR == clk_unit_pkg::CTRL_ONE_OFS) begin
        ctrl1_q <= I_WB_DAT[7:0];
      end else if (I_WB_ADR == clk_unit_pkg::CTRL_TWO_OFS) begin
        ctrl2_q <= I_WB_DAT[7:0];
      end
    end
  end

  // trim survives ordinary resets, so it hangs on power-on reset only
  always_ff @(posedge I_REF_CLK or posedge I_POR) begin
    if (I_POR) begin
      trim_q <= clk_unit_pkg::TRIM_POR; // R12
      fine_trim_q <= clk_unit_pkg::FINE_TRIM_POR; // R12
    end else if (wr_go && I_WB_ADR == clk_unit_pkg::TRIM_OFS) begin
      trim_q <= I_WB_DAT[7:0]; // R13 R18
    end else if (wr_go && I_WB_ADR == clk_unit_pkg::STAT_OFS) begin
      fine_trim_q <= I_WB_DAT[clk_unit_pkg::ST_FINE_BIT]; // R18
    end
  end

  // reserved source code behaves as loop output
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      act_src_q <= clk_unit_pkg::SRC_LOOP;
    end else if (out_tick || act_src_q == 2'h3) begin
      // switch only on an output tick boundary: no runt cycle
      act_src_q <= (req_src == 2'h3) ? clk_unit_pkg::SRC_LOOP : req_src; // R24
    end
  end

  always_comb begin
    mode_d = clk_unit_pkg::MODE_ENG_INT;
    if (I_STOP) begin
      mode_d = clk_unit_pkg::MODE_STOP; // R09
    end else if (act_src_q == clk_unit_pkg::SRC_IREF) begin
      mode_d = (lp_by && !I_DEBUG_ACTIVE) ? clk_unit_pkg::MODE_BYP_INT_LP
                                          : clk_unit_pkg::MODE_BYP_INT; // R23
    end else if (act_src_q == clk_unit_pkg::SRC_EREF) begin
      mode_d = (lp_by && !I_DEBUG_ACTIVE) ? clk_unit_pkg::MODE_BYP_EXT_LP
                                          : clk_unit_pkg::MODE_BYP_EXT; // R23
    end else if (iref_sel) begin
      mode_d = clk_unit_pkg::MODE_ENG_INT; // R22
    end else begin
      mode_d = clk_unit_pkg::MODE_ENG_EXT; // R22
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      mode_q <= clk_unit_pkg::MODE_ENG_INT; // R02
    end else begin
      mode_q <= mode_d; // R01 R24
    end
  end

  always_comb begin
    case (mode_q)
      clk_unit_pkg::MODE_ENG_INT: loop_run = 1'b1; // R03
      clk_unit_pkg::MODE_ENG_EXT: loop_run = 1'b1; // R04
      clk_unit_pkg::MODE_BYP_INT: loop_run = 1'b1; // R05
      clk_unit_pkg::MODE_BYP_EXT: loop_run = 1'b1; // R07
      default: loop_run = 1'b0; // R06 R08 R09
    endcase
  end

  always_comb begin
    case (mode_q)
      clk_unit_pkg::MODE_ENG_INT: src_tick = I_LOOP_TICK; // R03
      clk_unit_pkg::MODE_ENG_EXT: src_tick = I_LOOP_TICK; // R04
      clk_unit_pkg::MODE_BYP_INT: src_tick = I_IREF_TICK; // R05
      clk_unit_pkg::MODE_BYP_INT_LP: src_tick = I_IREF_TICK; // R06
      clk_unit_pkg::MODE_BYP_EXT: src_tick = I_EREF_TICK; // R07
      clk_unit_pkg::MODE_BYP_EXT_LP: src_tick = I_EREF_TICK; // R08
      default: src_tick = 1'b0; // R09
    endcase
  end

  assign ref_tick = iref_sel ? I_IREF_TICK : I_EREF_TICK; // R22

  clk_pow2_div #(.SEL_W(2)) u_bus_div (
    .I_REF_CLK(I_REF_CLK),
    .I_RST(I_RST),
    .i_tick(src_tick),
    .i_sel(bus_divider_select_sel),
    .o_tick(out_tick)
  ); // R14 R15

  // codes 6 and 7 still follow 2**code
  clk_pow2_div #(.SEL_W(3)) u_ref_div (
    .I_REF_CLK(I_REF_CLK),
    .I_RST(I_RST),
    .i_tick(ref_tick && loop_run),
    .i_sel(reference_divider_select_sel),
    .o_tick(O_LOOP_REF_TICK)
  ); // R16 R21

  clk_half_div u_bus_half (
    .I_REF_CLK(I_REF_CLK),
    .I_RST(I_RST),
    .i_tick(out_tick),
    .i_run(1'b1),
    .o_tick(O_BUS_TICK)
  ); // R10

  clk_half_div u_dbg_half (
    .I_REF_CLK(I_REF_CLK),
    .I_RST(I_RST),
    .i_tick(I_LOOP_TICK),
    .i_run(loop_run),
    .o_tick(O_DEBUG_TICK)
  ); // R17

  assign O_OUT_TICK = out_tick;
  assign O_LOOP_ENABLE = loop_run;
  assign O_MODE = mode_q;
  assign O_TRIM = trim_q;
  assign O_FINE_TRIM = fine_trim_q;

  // internal ref kept in stop only with its keep bit (regulator is software's)
  always_comb begin
    if (mode_q == clk_unit_pkg::MODE_STOP) begin
      O_IREF_ENABLE = ctrl1_q[clk_unit_pkg::IRSTOP_BIT]; // R09 R19
    end else begin
      O_IREF_ENABLE = ctrl1_q[clk_unit_pkg::IRCLK_BIT] || iref_sel ||
                      act_src_q == clk_unit_pkg::SRC_IREF;
    end
  end
  assign O_IREF_CLK_TICK = O_IREF_ENABLE && ctrl1_q[clk_unit_pkg::IRCLK_BIT]
                           && I_IREF_TICK;

  always_comb begin
    O_OSC_CTRL.osc_high_gain = ctrl2_q[clk_unit_pkg::HGAIN_BIT]; // R20
    O_OSC_CTRL.range_high = ctrl2_q[clk_unit_pkg::RANGE_BIT]; // R20
    O_OSC_CTRL.external_ref_osc_request = ctrl2_q[clk_unit_pkg::EOSC_BIT];
    O_OSC_CTRL.external_ref_stop_keep = ctrl2_q[clk_unit_pkg::ESTOP_BIT];
    if (mode_q == clk_unit_pkg::MODE_STOP) begin
      O_OSC_CTRL.external_ref_clock_on = ctrl2_q[clk_unit_pkg::ECLK_BIT] &&
                                         ctrl2_q[clk_unit_pkg::ESTOP_BIT];
    end else begin
      O_OSC_CTRL.external_ref_clock_on = ctrl2_q[clk_unit_pkg::ECLK_BIT];
    end
  end

  // wishbone: ack one cycle after strobe, dropped the cycle after
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= I_WB_CYC && I_WB_STB && !ack_q;
      if (I_WB_CYC && I_WB_STB && !ack_q) begin
        if (I_WB_ADR == clk_unit_pkg::CTRL_ONE_OFS) begin
          rdat_q <= {24'h000000, ctrl1_q};
        end else if (I_WB_ADR == clk_unit_pkg::CTRL_TWO_OFS) begin
          rdat_q <= {24'h000000, ctrl2_q};
        end else if (I_WB_ADR == clk_unit_pkg::TRIM_OFS) begin
          rdat_q <= {24'h000000, trim_q};
        end else if (I_WB_ADR == clk_unit_pkg::STAT_OFS) begin
          rdat_q <= {27'h0000000, iref_sel, act_src_q, 1'b0, fine_trim_q};
        end else begin
          rdat_q <= 32'h0000_0000;
        end
      end
    end
  end
  assign O_WB_ACK = ack_q;
  assign O_WB_DAT = rdat_q;

  a_reset_mode: assert property (@(posedge I_REF_CLK)
    $fell(I_RST) |-> mode_q == clk_unit_pkg::MODE_ENG_INT) // R02
    else $error("mode not engaged internal after reset");
  a_stop_silent: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    mode_q == clk_unit_pkg::MODE_STOP |-> !O_OUT_TICK && !O_DEBUG_TICK
    && !O_LOOP_ENABLE) // R09
    else $error("clock produced in stop");
  a_lp_no_debug: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (mode_q == clk_unit_pkg::MODE_BYP_INT_LP ||
     mode_q == clk_unit_pkg::MODE_BYP_EXT_LP) |-> !O_DEBUG_TICK) // R06 R08
    else $error("debug clock in low power bypass");
  a_lp_debug_keep: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    ##1 (lp_by && I_DEBUG_ACTIVE && !I_STOP && $stable(act_src_q))
    |=> O_LOOP_ENABLE) // R23
    else $error("loop disabled while debug active");
  a_bus_divider_select_reset: assert property (@(posedge I_REF_CLK)
    $fell(I_RST) |-> bus_divider_select_sel == clk_unit_pkg::BUSDIV_RST) // R11
    else $error("bus divider reset wrong");
  a_bus_half: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    O_BUS_TICK |-> O_OUT_TICK) // R10
    else $error("bus tick without output tick");
  a_iref_src: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    mode_q == clk_unit_pkg::MODE_BYP_INT && O_OUT_TICK |-> I_IREF_TICK) // R05
    else $error("bypass internal not from internal ref");
  a_eref_src: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    mode_q == clk_unit_pkg::MODE_BYP_EXT && O_OUT_TICK |-> I_EREF_TICK) // R07
    else $error("bypass external not from external ref");
  a_engaged_src: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (mode_q == clk_unit_pkg::MODE_ENG_INT ||
     mode_q == clk_unit_pkg::MODE_ENG_EXT) && O_OUT_TICK |-> I_LOOP_TICK)
    else $error("engaged mode not from loop"); // R03 R04
  a_debug_src: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    O_DEBUG_TICK |-> I_LOOP_TICK && O_LOOP_ENABLE) // R17
    else $error("debug tick not from loop");
  a_trim_keep: assert property (@(posedge I_REF_CLK) disable iff (I_POR)
    $rose(I_RST) |=> $stable(trim_q)) // R13
    else $error("trim changed by ordinary reset");
  a_wb_ack: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    I_WB_CYC && I_WB_STB && !ack_q |=> O_WB_ACK ##1 !O_WB_ACK)
    else $error("wishbone ack timing wrong");
  a_osc_ctrl: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    O_OSC_CTRL.osc_high_gain == ctrl2_q[clk_unit_pkg::HGAIN_BIT] &&
    O_OSC_CTRL.range_high == ctrl2_q[clk_unit_pkg::RANGE_BIT]) // R20
    else $error("oscillator control mismatch");

  c_eng_ext: cover property (@(posedge I_REF_CLK)
    mode_q == clk_unit_pkg::MODE_ENG_EXT);
  c_byp_int_low: cover property (@(posedge I_REF_CLK)
    mode_q == clk_unit_pkg::MODE_BYP_INT_LP);
  c_byp_ext_out: cover property (@(posedge I_REF_CLK)
    mode_q == clk_unit_pkg::MODE_BYP_EXT && O_OUT_TICK);
  c_stop: cover property (@(posedge I_REF_CLK)
    mode_q == clk_unit_pkg::MODE_STOP);
endmodule // clk_unit_ctrl
`default_nettype wire

// >>> rtl/clk_unit_pkg.sv
// shared constants and types for the clock source and mode control unit
`default_nettype none
package clk_unit_pkg;
  // register byte offsets
  localparam logic [3:0] CTRL_ONE_OFS = 4'h0;
  localparam logic [3:0] CTRL_TWO_OFS = 4'h4;
  localparam logic [3:0] TRIM_OFS = 4'h8;
  localparam logic [3:0] STAT_OFS = 4'hC;

  // control one fields
  localparam int SRC_LSB = 6;
  localparam int REFDIV_LSB = 3;
  localparam int IREF_BIT = 2;
  localparam int IRCLK_BIT = 1;
  localparam int IRSTOP_BIT = 0;
  // control two fields
  localparam int BUSDIV_LSB = 6;
  localparam int RANGE_BIT = 5;
  localparam int HGAIN_BIT = 4;
  localparam int LPBY_BIT = 3;
  localparam int EOSC_BIT = 2;
  localparam int ECLK_BIT = 1;
  localparam int ESTOP_BIT = 0;
  // status fields
  localparam int ST_IREF_BIT = 4;
  localparam int ST_SRC_LSB = 2;
  localparam int ST_FINE_BIT = 0;

  // reset values
  localparam logic [1:0] SRC_RST = 2'h0;
  localparam logic [2:0] REFDIV_RST = 3'h0;
  localparam logic [1:0] BUSDIV_RST = 2'h1;
  localparam logic [7:0] TRIM_POR = 8'h80;
  localparam logic FINE_TRIM_POR = 1'b0;

  // clock source select codes
  localparam logic [1:0] SRC_LOOP = 2'h0;
  localparam logic [1:0] SRC_IREF = 2'h1;
  localparam logic [1:0] SRC_EREF = 2'h2;

  typedef enum logic [6:0] {
    MODE_ENG_INT = 7'h01,
    MODE_ENG_EXT = 7'h02,
    MODE_BYP_INT = 7'h04,
    MODE_BYP_INT_LP = 7'h08,
    MODE_BYP_EXT = 7'h10,
    MODE_BYP_EXT_LP = 7'h20,
    MODE_STOP = 7'h40
  } mode_t;

  typedef struct packed {
    logic osc_high_gain;
    logic range_high;
    logic external_ref_osc_request;
    logic external_ref_clock_on;
    logic external_ref_stop_keep;
  } osc_ctrl_t;
endpackage : clk_unit_pkg
`default_nettype wire

// >>> rtl/clk_pow2_div.sv
// power-of-two clock-enable divider, ratio 2**sel
`default_nettype none
module clk_pow2_div #(
  parameter int SEL_W = 2
) (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic i_tick,
  input wire logic [SEL_W-1:0] i_sel,
  output logic o_tick
);
  localparam int CNT_W = (1 << SEL_W);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] mask;

  always_comb begin
    mask = '0;
    for (int k = 0; k < CNT_W; k++) begin
      if (k < int'(i_sel)) begin
        mask[k] = 1'b1;
      end
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      cnt_q <= '0;
    end else if (i_tick) begin
      cnt_q <= ((cnt_q & mask) == mask) ? '0 : cnt_q + 1'b1;
    end
  end

  assign o_tick = i_tick && ((cnt_q & mask) == mask);
endmodule // clk_pow2_div
`default_nettype wire

// >>> rtl/clk_half_div.sv
// fixed divide-by-two toggle for a clock-enable stream
`default_nettype none
module clk_half_div (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic i_tick,
  input wire logic i_run,
  output logic o_tick
);
  logic ph_q;
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      ph_q <= 1'b0;
    end else if (!i_run) begin
      ph_q <= 1'b0;
    end else if (i_tick) begin
      ph_q <= ~ph_q;
    end
  end
  assign o_tick = i_run && i_tick && ph_q;
endmodule // clk_half_div
`default_nettype wire

// >>> test/clk_src_model.sv
// source clock tick generators and a tick-gap meter for the bench
`default_nettype none
module clk_src_model #(
  parameter int LOOP_P = 3,
  parameter int IREF_P = 5,
  parameter int EREF_P = 7
) (
  input wire logic clk,
  input wire logic rst,
  output logic loop_tick,
  output logic iref_tick,
  output logic eref_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  int c = 0;
  always @(posedge clk or posedge rst) begin
    if (rst)
      c <= 0;
    else
      c <= c + 1;
  end
  // coprime periods so that source switches land out of step
  assign loop_tick = (c % LOOP_P) == LOOP_P - 1;
  assign iref_tick = (c % IREF_P) == IREF_P - 1;
  assign eref_tick = (c % EREF_P) == EREF_P - 1;
endmodule // clk_src_model

module tick_gap (
  input wire logic clk,
  input wire logic base,
  input wire logic evt,
  output int gap
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial gap = 0;
  // gap counts base ticks up to and including the one carrying evt
  always @(posedge clk) begin
    if (base && evt) begin
      gap <= cnt + 1;
      cnt <= 0;
    end else if (base) begin
      cnt <= cnt + 1;
    end
  end
endmodule // tick_gap
`default_nettype wire

// >>> test/fll_clock_source_mode_control_tb.sv
// self-checking bench for the clock source and mode control unit
`default_nettype none
module fll_clock_source_mode_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, por, stop, dbg, cyc, stb, we;
  logic [3:0] adr, sel;
  logic [31:0] wdat, rdat, wb_q;
  logic ack, lt, it, et, out_t, bus_t, dbg_t, ref_t, loop_en, fine_trim;
  logic [7:0] trim, r, c1, c2, tr;
  logic ft;
  logic iref_en, irc_t;
  int n_irc = 0;
  clk_unit_pkg::osc_ctrl_t osc;
  clk_unit_pkg::mode_t mode;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int src = 0;
  int n_out = 0;
  int n_dbg = 0;
  int g_out, g_bus, g_dbg, g_ref, d0, o0, i0;
  logic [7:0] t1 [7] = '{8'h04, 8'h00, 8'h44, 8'h44, 8'h80, 8'h80, 8'h80};
  logic tlp [7] = '{0, 0, 0, 1, 0, 1, 1};
  logic tdg [7] = '{0, 0, 0, 0, 0, 0, 1};

  clk_unit_ctrl u_clk_unit_ctrl (.I_REF_CLK(clk), .I_RST(rst), .I_POR(por),
    .I_STOP(stop), .I_DEBUG_ACTIVE(dbg), .I_LOOP_TICK(lt), .I_IREF_TICK(it),
    .I_EREF_TICK(et), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(wb_q),
    .O_WB_ACK(ack), .O_OUT_TICK(out_t), .O_BUS_TICK(bus_t),
    .O_DEBUG_TICK(dbg_t), .O_LOOP_REF_TICK(ref_t), .O_LOOP_ENABLE(loop_en),
    .O_IREF_ENABLE(iref_en), .O_IREF_CLK_TICK(irc_t), .O_TRIM(trim),
    .O_FINE_TRIM(fine_trim), .O_OSC_CTRL(osc), .O_MODE(mode));
  clk_src_model u_clk_src_model (.clk(clk), .rst(rst), .loop_tick(lt),
    .iref_tick(it), .eref_tick(et));
  tick_gap u_g_out (.clk(clk), .evt(out_t),
    .base(src == 1 ? it : src == 2 ? et : lt), .gap(g_out));
  tick_gap u_g_bus (.clk(clk), .base(out_t), .evt(bus_t), .gap(g_bus));
  tick_gap u_g_dbg (.clk(clk), .base(lt), .evt(dbg_t), .gap(g_dbg));
  tick_gap u_g_ref (.clk(clk), .base(c1[2] ? it : et), .evt(ref_t),
    .gap(g_ref));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    n_out <= n_out + int'(out_t);
    n_dbg <= n_dbg + int'(dbg_t);
    n_irc <= n_irc + int'(irc_t);
    if (cycles == 20000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic close_out();
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n == 20)
      n_errors++;
    rdat = wb_q;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
    if (w) begin
      case (a)
        4'h0: c1 = d;
        4'h4: c2 = d;
        4'h8: tr = d;
        4'hC: ft = d[0];
        default: ;
      endcase
    end
  endtask

  function automatic logic [31:0] rexp(input logic [3:0] a);
    case (a)
      4'h0: return {24'h0, c1};
      4'h4: return {24'h0, c2};
      4'h8: return {24'h0, tr};
      4'hC: return {27'h0, c1[2], c1[7:6], 1'b0, ft};
      default: return 32'h0;
    endcase
  endfunction

  function automatic clk_unit_pkg::mode_t mexp();
    if (stop)
      return clk_unit_pkg::MODE_STOP;
    case (c1[7:6])
      2'h1: return (c2[3] && !dbg) ? clk_unit_pkg::MODE_BYP_INT_LP :
        clk_unit_pkg::MODE_BYP_INT;
      2'h2: return (c2[3] && !dbg) ? clk_unit_pkg::MODE_BYP_EXT_LP :
        clk_unit_pkg::MODE_BYP_EXT;
      default: return c1[2] ? clk_unit_pkg::MODE_ENG_INT :
        clk_unit_pkg::MODE_ENG_EXT;
    endcase
  endfunction

  task automatic rd_all();
    for (int a = 0; a < 16; a += 2) begin
      wb(1'b0, 4'(a), 8'h00);
      chk(rdat, rexp(4'(a)));
    end
  endtask

  task automatic pulse(input logic p);
    rst <= 1'b1;
    por <= p;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    @(posedge clk);
    c1 = 8'h04;
    c2 = 8'h40;
    if (p) begin
      tr = 8'h80;
      ft = 1'b0;
    end
    chk(32'(mode), 32'(clk_unit_pkg::MODE_ENG_INT));
    rd_all();
  endtask

  initial begin
    rst = 1'b1;
    por = 1'b1;
    stop = 1'b0;
    dbg = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    sel = 4'hF;
    wdat = 32'h0;
    c1 = 8'h04;
    c2 = 8'h40;
    tr = 8'h80;
    ft = 1'b0;
    void'($urandom(32'hCBB18A79));
    repeat (6) @(posedge clk);
    pulse(1'b1);
    repeat (60) @(posedge clk);
    chk(g_out, 2);
    for (int b = 0; b < 4; b++) begin
      wb(1'b1, 4'h4, 8'(b << 6));
      repeat (80) @(posedge clk);
      chk(g_out, 1 << b);
      chk(g_bus, 2);
      chk(g_dbg, 2);
    end
    for (int k = 0; k < 9; k++) begin
      wb(1'b1, 4'h0, k < 8 ? 8'((k << 3) | 4) : 8'h08);
      repeat (16 * (1 << (k % 8)) + 20) @(posedge clk);
      chk(g_ref, k < 8 ? 1 << k : 2);
    end
    foreach (t1[i]) begin
      wb(1'b1, 4'h0, t1[i]);
      wb(1'b1, 4'h4, tlp[i] ? 8'h48 : 8'h40);
      dbg <= tdg[i];
      src = int'(t1[i][7:6]);
      repeat (60) @(posedge clk);
      d0 = n_dbg;
      repeat (60) @(posedge clk);
      chk(32'(mode), 32'(mexp()));
      chk(32'(loop_en), 32'(!(src != 0 && c2[3] && !dbg)));
      chk(32'(n_dbg > d0), 32'(loop_en === 1'b1));
      chk(g_out, 2);
      wb(1'b0, 4'hC, 8'h00);
      chk(rdat, rexp(4'hC));
    end
    dbg <= 1'b0;
    // software has the regulator on in stop before keeping a ref
    stop <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      wb(1'b1, 4'h4, 8'(8'h42 | k));
      wb(1'b1, 4'h0, 8'(8'h82 | k));
      o0 = n_out;
      d0 = n_dbg;
      i0 = n_irc;
      repeat (40) @(posedge clk);
      chk(32'(mode), 32'(clk_unit_pkg::MODE_STOP));
      chk(32'(iref_en), 32'(k));
      chk(n_irc - i0, 8 * k);
      chk(32'(loop_en), 32'h0);
      chk(n_out - o0 + n_dbg - d0, 0);
      chk(32'(osc.external_ref_clock_on), 32'(k));
    end
    stop <= 1'b0;
    repeat (4) begin
      r = 8'($urandom);
      wb(1'b1, 4'h4, r);
      repeat (2) @(posedge clk);
      chk(32'(osc), 32'({r[4], r[5], r[2], r[1], r[0]}));
    end
    r = 8'($urandom);
    wb(1'b1, 4'h8, r);
    wb(1'b1, 4'hC, 8'h01);
    chk(32'({trim, fine_trim}), 32'({r, 1'b1}));
    pulse(1'b0);
    pulse(1'b1);
    close_out();
  end
endmodule // fll_clock_source_mode_control_tb
`default_nettype wire
